// >>> hw/stack_aux_defs.svh
// constants for the return stack and auxiliary register unit
// assumes a single core clock and an instruction decoder that issues one-cycle strobes
// Notes on behaviour
// RQ1: calls push program counter plus one
// RQ2: return loads program counter from stack top
// RQ3: table moves hold one stack level
// RQ4: taken interrupt pushes current program counter
// RQ5: pop copies top to accumulator, shifts up
// RQ6: push shifts down, writes accumulator to top
// RQ7: accumulator call branches there, uses level
// RQ8: two auxiliary registers, counter or pointer
// RQ9: pointer selects register supplying indirect address
// RQ10: load pointer immediate sets pointer value
// RQ11: indirect pointer change applies after instruction
// RQ12: selected register is address, optional post-step
// RQ13: step touches low nine bits only
// RQ14: modify instruction only steps selected register
// RQ15: load/store pick register by operand
// RQ16: nonzero branch tests before decrement
// RQ17: return stack holds four levels
`ifndef STACK_AUX_DEFS_SVH
`define STACK_AUX_DEFS_SVH
`define SA_STACK_DEPTH 4
`define SA_PC_WIDTH 12
`define SA_AUX_WIDTH 16
`define SA_AUX_COUNT_BITS 9
`define SA_PC_RESET 12'h000
`define SA_AUX_RESET 16'h0000
`define SA_STEP_ONE 12'h001
`endif

// >>> hw/stack_aux_pkg.sv
// types for the return stack and auxiliary register unit
// assumes nothing beyond the defs header
package stack_aux_pkg;
    // post-access step of an auxiliary register
    typedef enum logic [1:0] {
        STEP_NONE,
        STEP_INC,
        STEP_DEC
    } aux_step_t;
    // program flow operation for this cycle
    typedef enum logic [2:0] {
        FLOW_NONE,
        FLOW_CALL,
        FLOW_CALL_ACC,
        FLOW_RETURN,
        FLOW_INTERRUPT,
        FLOW_POP,
        FLOW_PUSH,
        FLOW_TABLE
    } flow_op_t;
endpackage

// >>> hw/aux_register.sv
// one auxiliary register: load, and nine-bit wrapping step
// assumes load and step are never requested together
`timescale 1ns/1ps
`include "stack_aux_defs.svh"
module aux_register #(
    parameter int WIDTH = `SA_AUX_WIDTH,
    parameter int COUNT_BITS = `SA_AUX_COUNT_BITS
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // control
    input wire logic load,
    input wire logic [WIDTH-1:0] loadValue,
    input wire stack_aux_pkg::aux_step_t step,
    // contents
    output logic [WIDTH-1:0] value
);
    // low field counts; upper bits ride along untouched
    logic [COUNT_BITS-1:0] countField;
    logic [COUNT_BITS-1:0] nextCount;
    logic [WIDTH-1:0] next_value;

    assign countField = value[COUNT_BITS-1:0];
    // wrap inside the counter field only, so a pointer never carries upward
    assign nextCount = (step == stack_aux_pkg::STEP_INC) ? countField + 1'b1 :
                       (step == stack_aux_pkg::STEP_DEC) ? countField - 1'b1 :
                       countField; // [RQ13]
    assign next_value = load ? loadValue : {value[WIDTH-1:COUNT_BITS], nextCount};

    // register update
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            value <= `SA_AUX_RESET;
        end else begin
            value <= next_value;
        end
    end
endmodule // aux_register

// >>> hw/stack_and_aux_addressing.sv
// return stack and auxiliary register address unit
// assumes the decoder gives one-cycle strobes on the core clock; all inputs are same-domain
// assumes software budgets stack levels; nothing here guards against overflow
`timescale 1ns/1ps
`include "stack_aux_defs.svh"
module stack_and_aux_addressing #(
    parameter int DEPTH = `SA_STACK_DEPTH,
    parameter int PC_WIDTH = `SA_PC_WIDTH,
    parameter int AUX_WIDTH = `SA_AUX_WIDTH
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // program flow request
    input wire stack_aux_pkg::flow_op_t flowOp,
    input wire logic tableDone,
    input wire logic [PC_WIDTH-1:0] programCounter,
    input wire logic [PC_WIDTH-1:0] callTarget,
    input wire logic [PC_WIDTH-1:0] accumulatorIn,
    // program flow answer
    output logic pcLoad,
    output logic [PC_WIDTH-1:0] pcValue,
    output logic accLoad,
    output logic [PC_WIDTH-1:0] accValue,
    output logic [PC_WIDTH-1:0] topOfStackEntry,
    output logic [2:0] stackUsed,
    // auxiliary register control
    input wire logic indirectAccess,
    input wire stack_aux_pkg::aux_step_t indirectStep,
    input wire logic pointerChange,
    input wire logic pointerNew,
    input wire logic loadPointerImmediate,
    input wire logic pointerImmediate,
    input wire logic modifyAuxReg,
    input wire logic loadAuxImmediate,
    input wire logic loadAuxFromMemory,
    input wire logic storeAuxToMemory,
    input wire logic auxSelect,
    input wire logic [AUX_WIDTH-1:0] auxLoadValue,
    input wire logic branchIfAuxNonzero,
    // auxiliary register answers
    output logic [AUX_WIDTH-1:0] dataAddress,
    output logic [AUX_WIDTH-1:0] auxStoreValue,
    output logic auxBranchTaken,
    output logic auxRegPointer
);
    // ---------------------------------------------------------------
    // return stack
    // ---------------------------------------------------------------
    // entry 0 is the top; a push shifts every level down by one
    // no read pointer: every level moves, which keeps the top a plain register
    logic [PC_WIDTH-1:0] stackMem [DEPTH];
    logic [2:0] next_stackUsed;
    logic doPush;
    logic doPop;
    logic tableHeld; // a table move is holding its level
    logic [PC_WIDTH-1:0] pushValue;

    // overflow past the bottom simply drops the oldest entry, as a
    // hardware stack with no guard would; software must budget levels
    assign doPush = (flowOp == stack_aux_pkg::FLOW_CALL) ||
                    (flowOp == stack_aux_pkg::FLOW_CALL_ACC) ||
                    (flowOp == stack_aux_pkg::FLOW_INTERRUPT) ||
                    (flowOp == stack_aux_pkg::FLOW_PUSH) ||
                    (flowOp == stack_aux_pkg::FLOW_TABLE && !tableHeld); // [RQ3] [RQ17]
    // a finishing table move gives back the level that it took
    assign doPop = (flowOp == stack_aux_pkg::FLOW_RETURN) ||
                   (flowOp == stack_aux_pkg::FLOW_POP) ||
                   (tableHeld && tableDone); // [RQ3]
    // value pushed depends on who occupies the level
    assign pushValue = (flowOp == stack_aux_pkg::FLOW_PUSH) ? accumulatorIn : // [RQ6]
                       (flowOp == stack_aux_pkg::FLOW_INTERRUPT) ? programCounter : // [RQ4]
                       (flowOp == stack_aux_pkg::FLOW_TABLE) ? programCounter + `SA_STEP_ONE :
                       programCounter + `SA_STEP_ONE; // [RQ1]
    // a push and a table release in one cycle: the push wins and the release is lost, except at
    // full depth, where the fill count drops by one; the decoder must never issue both at once
    // fill count saturates at the depth
    assign next_stackUsed = (doPush && stackUsed != 3'(DEPTH)) ? stackUsed + 3'd1 :
                            (doPop && stackUsed != 3'd0) ? stackUsed - 3'd1 :
                            stackUsed;

    // stack shift: push moves down then writes top, pop moves up
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            // reset clears every level
            for (int i = 0; i < DEPTH; i++) begin
                stackMem[i] <= `SA_PC_RESET;
            end
        end else if (doPush) begin
            // push: older levels slide down, newest lands on top
            for (int i = DEPTH - 1; i > 0; i--) begin
                stackMem[i] <= stackMem[i-1];
            end
            stackMem[0] <= pushValue; // [RQ6] [RQ1]
        end else if (doPop) begin
            // pop: levels slide up; the bottom keeps a stale copy
            for (int i = 0; i < DEPTH - 1; i++) begin
                stackMem[i] <= stackMem[i+1]; // [RQ5]
            end
        end
    end

    // fill level and table-hold flag
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            // empty stack, no table move pending
            stackUsed <= 3'd0;
            tableHeld <= 1'b0;
        end else begin
            stackUsed <= next_stackUsed;
            // a held table move releases its level when it finishes
            if (flowOp == stack_aux_pkg::FLOW_TABLE && !tableHeld) begin
                tableHeld <= 1'b1; // [RQ3]
            end else if (tableDone) begin
                tableHeld <= 1'b0;
            end
        end
    end

    assign topOfStackEntry = stackMem[0];

    // ---------------------------------------------------------------
    // program counter and accumulator answers
    // ---------------------------------------------------------------
    // pcLoad and accLoad are one-cycle pulses; accValue stays until the next pop, so the
    // core may sample it late, but pcValue takes callTarget on every cycle without a return or accumulator call
    // next values of the registered answers
    logic next_pcLoad;
    logic [PC_WIDTH-1:0] next_pcValue;
    logic next_accLoad;

    // target selection for the program counter
    assign next_pcLoad = (flowOp == stack_aux_pkg::FLOW_CALL) ||
                         (flowOp == stack_aux_pkg::FLOW_CALL_ACC) ||
                         (flowOp == stack_aux_pkg::FLOW_RETURN) ||
                         auxBranchTaken;
    assign next_pcValue = (flowOp == stack_aux_pkg::FLOW_RETURN) ? stackMem[0] : // [RQ2]
                          (flowOp == stack_aux_pkg::FLOW_CALL_ACC) ? accumulatorIn : // [RQ7]
                          callTarget;
    assign next_accLoad = (flowOp == stack_aux_pkg::FLOW_POP);

    // registered answers, one cycle after the request
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            // no load pending, values at the reset address
            pcLoad <= 1'b0;
            pcValue <= `SA_PC_RESET;
            accLoad <= 1'b0;
            accValue <= `SA_PC_RESET;
        end else begin
            pcLoad <= next_pcLoad;
            pcValue <= next_pcValue;
            accLoad <= next_accLoad;
            // popped value is caught from the top before it shifts away
            if (next_accLoad) begin
                accValue <= stackMem[0]; // [RQ5]
            end
        end
    end

    // ---------------------------------------------------------------
    // auxiliary registers
    // ---------------------------------------------------------------
    // both registers reset to zero and count in the low field only
    logic [AUX_WIDTH-1:0] auxValue [2];
    logic selectedNonzero;
    logic next_auxRegPointer;

    // pointer picks the register for indirect use
    assign dataAddress = auxValue[auxRegPointer]; // [RQ9] [RQ12]
    // explicit-operand store ignores the pointer
    // the store strobe only tells the core to write; the value always shows
    assign auxStoreValue = auxValue[auxSelect]; // [RQ15]
    // zero test happens on the value before the decrement
    assign selectedNonzero = (auxValue[auxRegPointer] != '0);
    assign auxBranchTaken = branchIfAuxNonzero && selectedNonzero; // [RQ16]
    // the counted decrement below runs whether or not the branch is taken

    // two instances of the register cell
    // a load and a step on one cell in one cycle: the load wins
    for (genvar g = 0; g < 2; g++) begin : gen_aux
        logic loadHere;
        stack_aux_pkg::aux_step_t stepHere;
        logic selHere;
        assign selHere = (auxRegPointer == 1'(g));
        // loads by operand, never by pointer
        assign loadHere = (loadAuxImmediate || loadAuxFromMemory) && (auxSelect == 1'(g)); // [RQ15]
        // step source: indirect post-step, modify, or counted branch
        assign stepHere = !selHere ? stack_aux_pkg::STEP_NONE :
                          branchIfAuxNonzero ? stack_aux_pkg::STEP_DEC : // [RQ16]
                          (modifyAuxReg || indirectAccess) ? indirectStep : // [RQ14] [RQ12]
                          stack_aux_pkg::STEP_NONE;
        aux_register #(
            .WIDTH(AUX_WIDTH),
            .COUNT_BITS(`SA_AUX_COUNT_BITS)
        ) u_aux (
            .clk_sys(clk_sys),
            .sys_rst(sys_rst),
            .load(loadHere),
            .loadValue(auxLoadValue),
            .step(stepHere),
            .value(auxValue[g]) // [RQ8]
        );
    end

    // ---------------------------------------------------------------
    // auxiliary register pointer
    // ---------------------------------------------------------------
    // new pointer lands at the edge ending the instruction, so the
    // current access still reads through the old selection
    assign next_auxRegPointer = loadPointerImmediate ? pointerImmediate : // [RQ10]
                                (indirectAccess && pointerChange) ? pointerNew : // [RQ11]
                                auxRegPointer;

    // pointer register
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            // reset selects register zero
            auxRegPointer <= 1'b0;
        end else begin
            // holds unless a load or an indirect change asks otherwise
            auxRegPointer <= next_auxRegPointer;
        end
    end
endmodule // stack_and_aux_addressing

// >>> dv/stack_aux_chk.sv
// concurrent checks on the return stack and auxiliary unit ports
// assumes one core clock and a synchronous active-high reset
`timescale 1ns/1ps
module stack_aux_chk #(
    parameter int PC_WIDTH = 12,
    parameter int AUX_WIDTH = 16
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // flow side
    input wire logic pcLoad,
    input wire logic accLoad,
    input wire stack_aux_pkg::flow_op_t flowOp,
    input wire logic [PC_WIDTH-1:0] programCounter,
    input wire logic [PC_WIDTH-1:0] callTarget,
    input wire logic [PC_WIDTH-1:0] accumulatorIn,
    input wire logic [PC_WIDTH-1:0] pcValue,
    input wire logic [PC_WIDTH-1:0] accValue,
    input wire logic [PC_WIDTH-1:0] topOfStackEntry,
    input wire logic [2:0] stackUsed,
    // auxiliary side
    input wire logic modifyAuxReg,
    input wire logic loadAuxImmediate,
    input wire logic loadAuxFromMemory,
    input wire logic pointerChange,
    input wire logic loadPointerImmediate,
    input wire logic pointerImmediate,
    input wire logic pointerNew,
    input wire logic indirectAccess,
    input wire stack_aux_pkg::aux_step_t indirectStep,
    input wire logic branchIfAuxNonzero,
    input wire logic auxBranchTaken,
    input wire logic auxRegPointer,
    input wire logic [AUX_WIDTH-1:0] dataAddress
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // a lone modify step: nothing else may move the selected register
    wire quietInc = modifyAuxReg && indirectStep == stack_aux_pkg::STEP_INC && !pointerChange
        && !loadAuxImmediate && !loadAuxFromMemory && !loadPointerImmediate
        && !branchIfAuxNonzero;
    AST_CALL_JUMP: assert property (flowOp == stack_aux_pkg::FLOW_CALL |=>
        pcLoad && pcValue == $past(callTarget)) else $error("call target wrong");
    AST_CALL_LINK: assert property (flowOp inside {stack_aux_pkg::FLOW_CALL,
        stack_aux_pkg::FLOW_CALL_ACC} |=> topOfStackEntry == $past(programCounter) + 1'b1)
        else $error("return address wrong");
    AST_RETURN: assert property (flowOp == stack_aux_pkg::FLOW_RETURN |=>
        pcLoad && pcValue == $past(topOfStackEntry)) else $error("return target wrong");
    AST_ACC_CALL: assert property (flowOp == stack_aux_pkg::FLOW_CALL_ACC && stackUsed < 3'h4
        |=> pcValue == $past(accumulatorIn) && stackUsed == $past(stackUsed) + 1'b1)
        else $error("indirect call wrong");
    AST_INTERRUPT: assert property (flowOp == stack_aux_pkg::FLOW_INTERRUPT |=>
        topOfStackEntry == $past(programCounter)) else $error("interrupt save wrong");
    AST_POP: assert property (flowOp == stack_aux_pkg::FLOW_POP && stackUsed != 3'h0 |=>
        accLoad && accValue == $past(topOfStackEntry)) else $error("pop wrong");
    AST_PUSH: assert property (flowOp == stack_aux_pkg::FLOW_PUSH |=>
        topOfStackEntry == $past(accumulatorIn)) else $error("push wrong");
    AST_DEPTH: assert property (stackUsed <= 3'h4) else $error("stack overfilled");
    AST_PTR_IMM: assert property (loadPointerImmediate |=>
        auxRegPointer == $past(pointerImmediate)) else $error("pointer load wrong");
    AST_PTR_LATE: assert property (indirectAccess && pointerChange && !loadPointerImmediate
        |=> auxRegPointer == $past(pointerNew)) else $error("pointer change wrong");
    AST_STEP_NINE: assert property (quietInc |=> dataAddress ==
        {$past(dataAddress[AUX_WIDTH-1:9]), $past(dataAddress[8:0]) + 9'h001})
        else $error("nine-bit step wrong");
    AST_BRANCH: assert property (branchIfAuxNonzero |->
        auxBranchTaken == (dataAddress != '0)) else $error("branch test wrong");
    AST_BRANCH_JUMP: assert property (auxBranchTaken && flowOp == stack_aux_pkg::FLOW_NONE
        |=> pcLoad && pcValue == $past(callTarget)) else $error("counted branch jump wrong");
    AST_BRANCH_DEC: assert property (branchIfAuxNonzero && !loadAuxImmediate
        && !loadAuxFromMemory && !loadPointerImmediate && !(indirectAccess && pointerChange)
        |=> dataAddress[8:0] == $past(dataAddress[8:0]) - 9'h001)
        else $error("counted branch step wrong");
    // main scenarios reached
    COV_RET: cover property (flowOp == stack_aux_pkg::FLOW_RETURN ##1 pcLoad);
    COV_FULL: cover property (stackUsed == 3'h4 && flowOp == stack_aux_pkg::FLOW_PUSH);
    COV_WRAP: cover property (quietInc && dataAddress[8:0] == 9'h1ff);
endmodule // stack_aux_chk

bind stack_and_aux_addressing stack_aux_chk #(.PC_WIDTH(PC_WIDTH), .AUX_WIDTH(AUX_WIDTH)) u_chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .pcLoad(pcLoad), .accLoad(accLoad), .flowOp(flowOp),
    .programCounter(programCounter), .callTarget(callTarget), .accumulatorIn(accumulatorIn),
    .pcValue(pcValue), .accValue(accValue), .topOfStackEntry(topOfStackEntry),
    .stackUsed(stackUsed), .modifyAuxReg(modifyAuxReg), .loadAuxImmediate(loadAuxImmediate),
    .loadAuxFromMemory(loadAuxFromMemory), .pointerChange(pointerChange),
    .loadPointerImmediate(loadPointerImmediate), .pointerImmediate(pointerImmediate),
    .pointerNew(pointerNew), .indirectAccess(indirectAccess), .indirectStep(indirectStep),
    .branchIfAuxNonzero(branchIfAuxNonzero), .auxBranchTaken(auxBranchTaken),
    .auxRegPointer(auxRegPointer), .dataAddress(dataAddress)
);

// >>> dv/tb_stack_and_aux_addressing.sv
// self-checking bench for the return stack and auxiliary register unit
// assumes the design, its package and the bound checker are compiled first
`timescale 1ns/1ps
module tb_stack_and_aux_addressing;
    `define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin badCount++; \
        $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
    // one flow row: op and inputs, then the value, top and fill expected
    typedef struct packed {
        stack_aux_pkg::flow_op_t op;
        logic [11:0] pc, tgt, acc, val, top;
        logic [2:0] used;
    } row_t;
    int checks = 0;
    int badCount = 0;
    logic clk_sys = 0, sys_rst = 1, tableDone = 0, pcLoad, accLoad, auxBranchTaken, expPc;
    stack_aux_pkg::flow_op_t flowOp = stack_aux_pkg::FLOW_NONE;
    stack_aux_pkg::aux_step_t indirectStep = stack_aux_pkg::STEP_NONE;
    logic [11:0] programCounter = '0, callTarget = '0, accumulatorIn = '0;
    logic [11:0] pcValue, accValue, topOfStackEntry;
    logic [2:0] stackUsed;
    logic indirectAccess = 0, pointerChange = 0, pointerNew = 0, loadPointerImmediate = 0;
    logic pointerImmediate = 0, modifyAuxReg = 0, loadAuxImmediate = 0, loadAuxFromMemory = 0;
    logic storeAuxToMemory = 0, auxSelect = 0, branchIfAuxNonzero = 0, auxRegPointer;
    logic [15:0] auxLoadValue = '0, dataAddress, auxStoreValue;
    // nesting walk: fill to four levels, then unwind
    row_t rows [8] = '{
        '{stack_aux_pkg::FLOW_CALL, 12'h010, 12'h100, 12'h000, 12'h100, 12'h011, 3'h1},
        '{stack_aux_pkg::FLOW_CALL_ACC, 12'h100, 12'h000, 12'h200, 12'h200, 12'h101, 3'h2},
        '{stack_aux_pkg::FLOW_INTERRUPT, 12'h200, 12'h000, 12'h000, 12'h000, 12'h200, 3'h3},
        '{stack_aux_pkg::FLOW_PUSH, 12'h000, 12'h000, 12'habc, 12'h000, 12'habc, 3'h4},
        '{stack_aux_pkg::FLOW_POP, 12'h000, 12'h000, 12'h000, 12'habc, 12'h200, 3'h3},
        '{stack_aux_pkg::FLOW_RETURN, 12'h000, 12'h000, 12'h000, 12'h200, 12'h101, 3'h2},
        '{stack_aux_pkg::FLOW_RETURN, 12'h000, 12'h000, 12'h000, 12'h101, 12'h011, 3'h1},
        '{stack_aux_pkg::FLOW_RETURN, 12'h000, 12'h000, 12'h000, 12'h011, 12'h000, 3'h0}};
    stack_and_aux_addressing u_dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .flowOp(flowOp), .tableDone(tableDone),
        .programCounter(programCounter), .callTarget(callTarget), .accumulatorIn(accumulatorIn),
        .pcLoad(pcLoad), .pcValue(pcValue), .accLoad(accLoad), .accValue(accValue),
        .topOfStackEntry(topOfStackEntry), .stackUsed(stackUsed),
        .indirectAccess(indirectAccess), .indirectStep(indirectStep),
        .pointerChange(pointerChange), .pointerNew(pointerNew),
        .loadPointerImmediate(loadPointerImmediate), .pointerImmediate(pointerImmediate),
        .modifyAuxReg(modifyAuxReg), .loadAuxImmediate(loadAuxImmediate),
        .loadAuxFromMemory(loadAuxFromMemory), .storeAuxToMemory(storeAuxToMemory),
        .auxSelect(auxSelect), .auxLoadValue(auxLoadValue),
        .branchIfAuxNonzero(branchIfAuxNonzero), .dataAddress(dataAddress),
        .auxStoreValue(auxStoreValue), .auxBranchTaken(auxBranchTaken),
        .auxRegPointer(auxRegPointer)
    );
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    // inputs move on the falling edge only
    task nx;
        @(negedge clk_sys);
    endtask
    task wrapUp;
        $display("checks %0d mismatches %0d", checks, badCount);
        if (badCount == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // watchdog: the whole run needs well under a microsecond
    initial begin
        #20000;
        badCount++;
        wrapUp();
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        nx;
        sys_rst = 0;
        `CHK("stackUsed", 3'h0, stackUsed)
        foreach (rows[i]) begin
            nx;
            {flowOp, programCounter, callTarget, accumulatorIn} =
                {rows[i].op, rows[i].pc, rows[i].tgt, rows[i].acc};
            @(posedge clk_sys);
            #1;
            expPc = rows[i].op inside {stack_aux_pkg::FLOW_CALL, stack_aux_pkg::FLOW_CALL_ACC,
                stack_aux_pkg::FLOW_RETURN};
            `CHK("pcLoad", expPc, pcLoad)
            `CHK("accLoad", rows[i].op == stack_aux_pkg::FLOW_POP, accLoad)
            if (expPc) `CHK("pcValue", rows[i].val, pcValue)
            if (rows[i].op == stack_aux_pkg::FLOW_POP) `CHK("accValue", rows[i].val, accValue)
            if (rows[i].used != 3'h0) `CHK("top", rows[i].top, topOfStackEntry)
            `CHK("stackUsed", rows[i].used, stackUsed)
        end
        // overflow drops the oldest, a pop at empty keeps the fill count at zero
        for (int k = 1; k <= 5; k++) begin
            nx;
            flowOp = stack_aux_pkg::FLOW_PUSH;
            accumulatorIn = 12'(k);
        end
        nx;
        flowOp = stack_aux_pkg::FLOW_POP;
        `CHK("stackUsed", 3'h4, stackUsed)
        for (int k = 5; k >= 2; k--) begin
            @(posedge clk_sys);
            #1;
            `CHK("accValue", 12'(k), accValue)
        end
        @(posedge clk_sys);
        nx;
        flowOp = stack_aux_pkg::FLOW_TABLE;
        programCounter = 12'h050;
        `CHK("stackUsed", 3'h0, stackUsed)
        nx;
        flowOp = stack_aux_pkg::FLOW_NONE;
        tableDone = 1;
        `CHK("stackUsed", 3'h1, stackUsed)
        nx;
        tableDone = 0;
        loadAuxImmediate = 1;
        auxLoadValue = 16'h31ff;
        `CHK("stackUsed", 3'h0, stackUsed)
        nx;
        {loadAuxImmediate, loadAuxFromMemory, auxSelect, auxLoadValue} = {2'b01, 1'b1, 16'ha000};
        nx;
        {loadAuxFromMemory, storeAuxToMemory} = 2'b01;
        #1;
        `CHK("auxStore", 16'ha000, auxStoreValue)
        `CHK("dataAddress", 16'h31ff, dataAddress)
        nx;
        {storeAuxToMemory, modifyAuxReg, indirectStep} = {2'b01, stack_aux_pkg::STEP_INC};
        nx;
        {modifyAuxReg, indirectAccess, pointerChange, pointerNew} = 4'b0111;
        indirectStep = stack_aux_pkg::STEP_DEC;
        `CHK("dataAddress", 16'h3000, dataAddress)
        `CHK("auxStore", 16'ha000, auxStoreValue)
        nx;
        {indirectAccess, pointerChange, branchIfAuxNonzero, auxSelect} = 4'b0010;
        #1;
        `CHK("pointer", 1'b1, auxRegPointer)
        `CHK("dataAddress", 16'ha000, dataAddress)
        `CHK("taken", 1'b1, auxBranchTaken)
        `CHK("auxStore", 16'h31ff, auxStoreValue)
        nx;
        {branchIfAuxNonzero, loadPointerImmediate, pointerImmediate, auxSelect} = 4'b0101;
        #1;
        `CHK("auxStore", 16'ha1ff, auxStoreValue)
        `CHK("pcLoad", 1'b1, pcLoad)
        `CHK("pcValue", 12'h000, pcValue)
        nx;
        {loadPointerImmediate, loadAuxImmediate, auxSelect, auxLoadValue} = {3'b010, 16'h0000};
        `CHK("pointer", 1'b0, auxRegPointer)
        nx;
        {loadAuxImmediate, branchIfAuxNonzero} = 2'b01;
        #1;
        `CHK("taken", 1'b0, auxBranchTaken)
        nx;
        branchIfAuxNonzero = 0;
        `CHK("pcLoad", 1'b0, pcLoad)
        `CHK("dataAddress", 16'h01ff, dataAddress)
        wrapUp();
    end
endmodule // tb_stack_and_aux_addressing
